// *** tb/cit_timing_assertions.sv ***
// Checker with timing properties bound onto the instruction timing block.
`default_nettype none
module cit_timing_checker
    import cit_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    input wire logic       issue_i,
    input wire logic [7:0] opcode_i,
    input wire logic       taken_i,
    input wire logic       ready_o,
    input wire logic [1:0] length_o,
    input wire logic [3:0] cycles_o,
    input wire logic       clear_bit_o,
    input wire logic       done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_accept;
        ready_o && issue_i;
    endsequence
    sequence s_long4;
        s_accept ##1 cycles_o == 4'h4;
    endsequence
    cycle_cap_a: assert property (
        cycles_o != 4'h0 && cycles_o <= CIT_MAX_CYCLES)
        else $error("Cycle count out of range.");
    single_step_a: assert property (
        s_accept ##1 cycles_o == 4'h1 |-> ready_o && done_o)
        else $error("Single cycle op not done at once.");
    long_wait_a: assert property (
        s_long4 |-> !ready_o [*3] ##1 (ready_o && done_o))
        else $error("Four cycle op paced wrongly.");
    call_time_a: assert property (
        s_accept ##0 opcode_i == 8'h12
        |=> length_o == 2'h3 && cycles_o == 4'h4)
        else $error("Long call timing wrong.");
    ret_time_a: assert property (
        s_accept ##0 opcode_i == 8'h22
        |=> length_o == 2'h1 && cycles_o == 4'h5)
        else $error("Return timing wrong.");
    cmp_branch_a: assert property (
        s_accept ##0 opcode_i == 8'hB5
        |=> cycles_o == ($past(taken_i) ? 4'h5 : 4'h4))
        else $error("Compare branch timing wrong.");
    bit_clear_a: assert property (
        s_accept ##0 (opcode_i == 8'h10 && taken_i) |=> clear_bit_o)
        else $error("Bit clear pulse missing.");
    clear_cause_a: assert property (
        clear_bit_o |-> $past(issue_i && ready_o && taken_i
                              && opcode_i == 8'h10))
        else $error("Bit clear pulse without cause.");
    hold_timing_a: assert property (
        !(ready_o && issue_i) |=> $stable(length_o) && $stable(cycles_o))
        else $error("Timing outputs changed without accept.");
endmodule
bind cit_timing cit_timing_checker u_chk (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .issue_i(issue_i),
    .opcode_i(opcode_i), .taken_i(taken_i), .ready_o(ready_o),
    .length_o(length_o), .cycles_o(cycles_o),
    .clear_bit_o(clear_bit_o), .done_o(done_o));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the instruction timing block.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       issue_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic       taken_i = 1'b0;
    logic       ready_o, clear_bit_o, done_o;
    logic [1:0] length_o;
    logic [3:0] cycles_o;
    int         failures = 0;
    int         checks = 0;
    cit_timing u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .issue_i(issue_i), .opcode_i(opcode_i), .taken_i(taken_i),
        .ready_o(ready_o), .length_o(length_o), .cycles_o(cycles_o),
        .clear_bit_o(clear_bit_o), .done_o(done_o));
    // Packs length, base cycles and branch class; zero for unlisted codes.
    function automatic logic [11:0] spec(logic [7:0] o);
        casez (o)
            8'h00, 8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC4, 8'hC3,
            8'hD3, 8'hB3, 8'b111?1???, 8'b11001???: return 12'h110;
            8'b11??011?: return 12'h120;
            8'h93, 8'h83, 8'hE0, 8'hF0, 8'h73, 8'b111?001?:
                return 12'h130;
            8'h22, 8'h32: return 12'h150;
            8'hE5, 8'h74, 8'hF5, 8'b1000011?, 8'b1010011?, 8'b0111011?,
            8'b10101???, 8'b01111???, 8'b10001???, 8'hC0, 8'hD0, 8'hC5,
            8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92:
                return 12'h220;
            8'h?1, 8'h80: return 12'h230;
            8'h63, 8'h85, 8'h75, 8'h90: return 12'h330;
            8'h02, 8'h12: return 12'h340;
            8'h40, 8'h50, 8'h60, 8'h70, 8'b11011???:
                return 12'h221;
            8'h20, 8'h30, 8'hB4, 8'hD5, 8'b10111???:
                return 12'h331;
            8'h10: return 12'h332;
            8'hB5, 8'b1011011?: return 12'h341;
            default: return 12'h000;
        endcase
    endfunction
    task automatic expect_eq(logic ok, string what);
        checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_rst();
        expect_eq(ready_o === 1'b1 && length_o === 2'h1 && cycles_o === 4'h1
            && done_o === 1'b0 && clear_bit_o === 1'b0, "reset values");
    endtask
    // Issues one op at a falling edge; scrambles inputs while refused.
    task automatic run(logic [7:0] op, logic tk);
        logic [11:0] e;
        logic [3:0]  n;
        e = spec(op);
        n = e[7:4] + {3'h0, tk && e[3:0] != 4'h0};
        issue_i = 1'b1;
        opcode_i = op;
        taken_i = tk;
        @(posedge clock_i);
        for (int k = 1; k <= n; k++) begin
            @(negedge clock_i);
            expect_eq(length_o === e[9:8] && cycles_o === n,
                "timing");
            expect_eq(ready_o === (k == n) && done_o === (k == n),
                "pace");
            expect_eq(clear_bit_o === (k == 1 && tk && e[3:0] == 4'h2),
                "clear pulse");
            if (k < n) begin
                opcode_i = 8'($urandom);
                taken_i = 1'($urandom);
            end
        end
    endtask
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        logic [7:0] op;
        void'($urandom(32'hE0010045));
        repeat (4) @(negedge clock_i);
        chk_rst();
        reset_n_i = 1'b1;
        @(negedge clock_i);
        $display("test done: reset");
        for (int i = 0; i < 512; i++) begin
            if (spec(8'(i)) != 12'h000) begin
                run(8'(i), i[8]);
            end
        end
        $display("test done: opcode table");
        repeat (300) begin
            do op = 8'($urandom); while (spec(op) == 12'h000);
            run(op, 1'($urandom));
            if ($urandom % 4 == 0) begin
                issue_i = 1'b0;
                @(negedge clock_i);
                expect_eq(ready_o === 1'b1 && done_o === 1'b0,
                    "idle");
            end
        end
        $display("test done: random stream");
        issue_i = 1'b1;
        opcode_i = 8'h22;
        @(posedge clock_i);
        @(negedge clock_i);
        reset_n_i = 1'b0;
        issue_i = 1'b0;
        #1;
        chk_rst();
        @(negedge clock_i);
        reset_n_i = 1'b1;
        @(negedge clock_i);
        run(8'h12, 1'b0);
        $display("test done: reset mid op");
        wrap_up();
    end
endmodule
`default_nettype wire

// *** verilog/cit_counter.sv ***
// Down counter that tracks remaining execution cycles.
`default_nettype none
module cit_counter
    import cit_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic       load_i,
    input  wire logic [3:0] value_i,
    output logic      [3:0] count_o
);
    logic [3:0] next_count;
    always_comb begin
        next_count = count_o;
        if (load_i) begin
            next_count = value_i;
        end else if (count_o != CIT_CNT_ZERO) begin
            next_count = count_o - CIT_CYC_ONE;
        end
    end
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_o <= CIT_CNT_ZERO;
        end else begin
            count_o <= next_count;
        end
    end
endmodule
`default_nettype wire

// *** verilog/cit_decode.sv ***
// Opcode decoder giving byte length, base cycles and branch class.
`default_nettype none
module cit_decode
    import cit_pkg::*;
(
    input  wire logic [7:0] opcode_i,
    output logic      [1:0] length_o,
    output logic      [3:0] cycles_o,
    output cit_br_t         branch_o
);
    always_comb begin
        length_o = CIT_LEN_1;
        cycles_o = CIT_CYC_1;
        branch_o = CIT_BR_NONE;
        casez (opcode_i)
            8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: begin
                length_o = CIT_LEN_1;
                cycles_o = CIT_CYC_1;
            end
            8'h63: begin
                length_o = CIT_LEN_3;
                cycles_o = CIT_CYC_3;
            end
            8'b1110_1???, 8'b1111_1???, 8'b1100_1???, 8'h00,
            8'hC3, 8'hD3, 8'hB3: begin
                length_o = CIT_LEN_1;
                cycles_o = CIT_CYC_1;
            end
            8'hE5, 8'h74, 8'b1010_1???, 8'b0111_1???, 8'hF5,
            8'b1000_1???, 8'h86, 8'h87, 8'hA6, 8'hA7, 8'h76, 8'h77,
            8'hC0, 8'hD0,
            8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0,
            8'hA2, 8'h92: begin
                length_o = CIT_LEN_2;
                cycles_o = CIT_CYC_2;
            end
            8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7, 8'hD6, 8'hD7: begin
                length_o = CIT_LEN_1;
                cycles_o = CIT_CYC_2;
            end
            8'h85, 8'h75, 8'h90: begin
                length_o = CIT_LEN_3;
                cycles_o = CIT_CYC_3;
            end
            8'h93, 8'h83, 8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3,
            8'h73: begin
                length_o = CIT_LEN_1;
                cycles_o = CIT_CYC_3;
            end
            8'b???1_0001, 8'b???0_0001, 8'h80: begin
                length_o = CIT_LEN_2;
                cycles_o = CIT_CYC_3;
            end
            8'h12, 8'h02: begin
                length_o = CIT_LEN_3;
                cycles_o = CIT_CYC_4;
            end
            8'h22, 8'h32: begin
                length_o = CIT_LEN_1;
                cycles_o = CIT_CYC_5;
            end
            8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: begin
                length_o = CIT_LEN_2;
                cycles_o = CIT_CYC_2;
                branch_o = CIT_BR_COND;
            end
            8'h20, 8'h30, 8'hD5, 8'hB4, 8'b1011_1???: begin
                length_o = CIT_LEN_3;
                cycles_o = CIT_CYC_3;
                branch_o = CIT_BR_COND;
            end
            8'h10: begin
                length_o = CIT_LEN_3;
                cycles_o = CIT_CYC_3;
                branch_o = CIT_BR_BITCLR;
            end
            8'hB5, 8'hB6, 8'hB7: begin
                length_o = CIT_LEN_3;
                cycles_o = CIT_CYC_4;
                branch_o = CIT_BR_COND;
            end
            default: begin
                length_o = CIT_LEN_1;
                cycles_o = CIT_CYC_1;
            end
        endcase
    end
endmodule
`default_nettype wire

// *** verilog/cit_pkg.sv ***
// Package with lengths, cycle counts, branch classes and states for timing control.
`default_nettype none
package cit_pkg;
    localparam logic [3:0] CIT_MAX_CYCLES = 4'h8;
    localparam logic [1:0] CIT_LEN_1      = 2'h1;
    localparam logic [1:0] CIT_LEN_2      = 2'h2;
    localparam logic [1:0] CIT_LEN_3      = 2'h3;
    localparam logic [3:0] CIT_CYC_1      = 4'h1;
    localparam logic [3:0] CIT_CYC_2      = 4'h2;
    localparam logic [3:0] CIT_CYC_3      = 4'h3;
    localparam logic [3:0] CIT_CYC_4      = 4'h4;
    localparam logic [3:0] CIT_CYC_5      = 4'h5;
    localparam logic [3:0] CIT_CYC_ONE    = 4'h1;
    localparam logic [3:0] CIT_CNT_ZERO   = 4'h0;
    typedef enum logic [1:0] {
        CIT_BR_NONE,
        CIT_BR_COND,
        CIT_BR_BITCLR
    } cit_br_t;
    typedef enum {
        CIT_IDLE,
        CIT_EXEC
    } cit_state_t;
endpackage
`default_nettype wire

// *** verilog/cit_timing.sv ***
// Instruction length and execution timing control for the core pipeline.
// Overview of operation
// - No instruction exceeds eight cycles.
// - Accumulator unary ops: one byte, one cycle.
// - XOR immediate into direct: three bytes, three cycles.
// - Accumulator loads take one or two cycles.
// - Register and direct stores: one to three.
// - Direct-to-direct moves: three bytes, three cycles.
// - Indirect RAM writes take two cycles.
// - Pointer load constant: three bytes, three cycles.
// - Code memory reads: one byte, three cycles.
// - External data moves: one byte, three cycles.
// - Push and pop: two bytes, two cycles.
// - Exchanges take one or two cycles.
// - Carry ops one cycle, bit ops two.
// - Carry/zero branches: two bytes, two/three cycles.
// - Bit branches three/four cycles; clear variant clears.
// - Calls, returns, jumps have fixed timing.
// - Decrement branches: two/three or three/four cycles.
// - Compare branches: three/four or four/five cycles.
`default_nettype none
module cit_timing
    import cit_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic       issue_i,
    input  wire logic [7:0] opcode_i,
    input  wire logic       taken_i,
    output logic            ready_o,
    output logic      [1:0] length_o,
    output logic      [3:0] cycles_o,
    output logic            clear_bit_o,
    output logic            done_o
);
    logic       [1:0] dec_length;
    logic       [3:0] dec_cycles;
    cit_br_t          dec_branch;
    logic       [3:0] count;
    logic       [3:0] exec_cycles;
    logic             accept;
    cit_state_t       state;
    cit_state_t       next_state;
    logic             next_ready;
    logic       [1:0] next_length;
    logic       [3:0] next_cycles;
    logic             next_clear_bit;
    logic             next_done;

    cit_decode u_decode (
        .opcode_i (opcode_i),
        .length_o (dec_length),
        .cycles_o (dec_cycles),
        .branch_o (dec_branch)
    );

    cit_counter u_counter (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .load_i    (accept),
        .value_i   (exec_cycles),
        .count_o   (count)
    );

    always_comb begin
        accept      = issue_i && ready_o;
        exec_cycles = dec_cycles;
        if (dec_branch != CIT_BR_NONE && taken_i) begin
            exec_cycles = dec_cycles + CIT_CYC_ONE;
        end
        if (exec_cycles > CIT_MAX_CYCLES) begin
            exec_cycles = CIT_MAX_CYCLES;
        end
        exec_cycles = exec_cycles - CIT_CYC_ONE;
    end

    always_comb begin
        next_state     = state;
        next_ready     = ready_o;
        next_length    = length_o;
        next_cycles    = cycles_o;
        next_clear_bit = 1'b0;
        next_done      = 1'b0;
        case (state)
            CIT_IDLE: begin
                if (accept) begin
                    next_length    = dec_length;
                    next_cycles    = exec_cycles + CIT_CYC_ONE;
                    next_clear_bit = (dec_branch == CIT_BR_BITCLR)
                                     && taken_i;
                    if (exec_cycles == CIT_CNT_ZERO) begin
                        next_done = 1'b1;
                    end else begin
                        next_ready = 1'b0;
                        next_state = CIT_EXEC;
                    end
                end
            end
            CIT_EXEC: begin
                if (count == CIT_CYC_ONE) begin
                    next_ready = 1'b1;
                    next_done  = 1'b1;
                    next_state = CIT_IDLE;
                end
            end
            default: begin
                next_state = CIT_IDLE;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state       <= CIT_IDLE;
            ready_o     <= 1'b1;
            length_o    <= CIT_LEN_1;
            cycles_o    <= CIT_CYC_1;
            clear_bit_o <= 1'b0;
            done_o      <= 1'b0;
        end else begin
            state       <= next_state;
            ready_o     <= next_ready;
            length_o    <= next_length;
            cycles_o    <= next_cycles;
            clear_bit_o <= next_clear_bit;
            done_o      <= next_done;
        end
    end
endmodule
`default_nettype wire
